// ---- design/sprsm_top.sv ----
// serial port pin roles, select modes, shifting and registers
// What this block does
// - mosi output as master, input as slave
// - master drives mosi from shift msb
// - miso sampled as master, driven as slave
// - miso off when disabled or unselected slave
// - 3-wire slave always drives miso from msb
// - master makes sck, slave receives it
// - unselected 4-wire slave ignores sck
// - mode 00: 3-wire, slave always selected
// - mode 01: select pin is input
// - mode 01 master: select fall disables master
// - mode 1x: select pin outputs low mode bit
// - select routed to pin except mode 00
// - master enable set means master, else slave
// - fault clears enables, sets fault flag
// - select low enables slave, fall resets count
// - eight bits set done, store receive byte unless a slave byte is still unread
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sprsm_top
   import sprsm_pkg::*;
(
   input wire logic clock, // system clock, 200 MHz
   input wire logic reset, // asynchronous, active high
   input wire logic [3:0] addr, // register byte address
   input wire logic [7:0] wdata, // register write data
   input wire logic wr_strobe, // one-cycle write
   input wire logic rd_strobe, // one-cycle read
   output logic [7:0] rdata, // read data, cycle after read
   output logic irq, // level interrupt
   input wire logic sck_in, // serial clock pin level
   output logic sck_out, // serial clock drive
   output logic sck_oe, // serial clock enable
   input wire logic mosi_in, // master-out pin level
   output logic mosi_out, // master-out drive
   output logic mosi_oe, // master-out enable
   input wire logic miso_in, // master-in pin level
   output logic miso_out, // master-in drive
   output logic miso_oe, // master-in enable
   input wire logic nss_in, // select pin level
   output logic nss_out, // select drive
   output logic nss_oe, // select enable
   output logic nss_routed // select mapped to a pin
);
   typedef struct packed {
      sprsm_st_e st;
      logic port_en;
      logic master_en;
      logic [1:0] mode;
      logic [3:0] stat;
      logic [3:0] mask;
      logic [7:0] shreg;
      logic rx_bit;
      logic [2:0] bitcnt;
      logic [4:0] half;
      logic [7:0] tx_buf;
      logic tx_full;
      logic sh_full;
      logic [7:0] rx_buf;
      logic rx_full;
      logic sck_d;
      logic nss_d;
      logic sck_out;
      logic sck_oe;
      logic mosi_out;
      logic mosi_oe;
      logic miso_out;
      logic miso_oe;
      logic nss_out;
      logic nss_oe;
      logic nss_routed;
      logic [7:0] rdata;
      logic irq;
   } sprsm_s;

   sprsm_s r;
   sprsm_s next_r;
   logic [SYNC_W-1:0] pin_q;
   logic sck_q;
   logic mosi_q;
   logic miso_q;
   logic nss_q;
   logic sck_rise;
   logic sck_fall;
   logic nss_fall;
   logic sel;
   logic fault;
   logic byte_done;
   logic [3:0] ev;

   // address match for the register port
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   // pin inputs pass two flops before any edge logic
   sprsm_sync u_sync (
      .clock(clock),
      .reset(reset),
      .din({nss_in, miso_in, mosi_in, sck_in}),
      .q(pin_q)
   );

   // synchronised levels and their edges
   assign sck_q = pin_q[SY_SCK];
   assign mosi_q = pin_q[SY_MOSI];
   assign miso_q = pin_q[SY_MISO];
   assign nss_q = pin_q[SY_NSS];
   assign sck_rise = sck_q && !r.sck_d;
   assign sck_fall = !sck_q && r.sck_d;
   assign nss_fall = r.nss_d && !nss_q;

   // slave selection: always in 3-wire, by low select in 4-wire
   assign sel = r.port_en && !r.master_en &&
      (r.mode == MODE_3W ||
      (r.mode == MODE_4W_IN && !nss_q));

   // multi-master fault on a select fall while master
   assign fault = r.port_en && r.master_en && r.mode == MODE_4W_IN &&
      nss_fall;

   // next state of the whole block
   always_comb begin
      next_r = r;
      ev = 4'h0;
      byte_done = 1'b0;
      next_r.sck_d = sck_q;
      next_r.nss_d = nss_q;

      // register writes
      if (wr_strobe && hit(addr, OFF_CTRL)) begin
         next_r.port_en = wdata[CT_EN];
         next_r.master_en = wdata[CT_MS];
         next_r.mode = wdata[CT_MODE_HI:CT_MODE_LO];
      end
      if (wr_strobe && hit(addr, OFF_MASK)) begin
         next_r.mask = wdata[3:0];
      end
      if (wr_strobe && hit(addr, OFF_DATA)) begin
         if (r.tx_full) begin
            ev[ST_WCOL] = 1'b1; // write ignored, buffer busy
         end else begin
            next_r.tx_buf = wdata;
            next_r.tx_full = 1'b1;
         end
      end

      // master sequencing
      case (r.st)
         SPRSM_IDLE: begin
            next_r.sck_out = 1'b0;
            if (r.port_en && r.master_en && r.sh_full) begin
               next_r.st = SPRSM_SHIFT;
               next_r.half = 5'h0;
               next_r.bitcnt = 3'h0;
            end
         end
         SPRSM_SHIFT: begin
            if (!r.port_en || !r.master_en) begin
               next_r.st = SPRSM_IDLE;
               next_r.sck_out = 1'b0;
            end else if (r.half == SCK_HALF_LAST) begin
               next_r.half = 5'h0;
               next_r.sck_out = !r.sck_out;
               if (!r.sck_out) begin
                  next_r.rx_bit = miso_q;
               end else begin
                  next_r.shreg = {r.shreg[6:0], r.rx_bit};
                  next_r.bitcnt = r.bitcnt + 3'h1;
                  if (r.bitcnt == LAST_BIT) begin
                     byte_done = 1'b1;
                     next_r.st = SPRSM_IDLE;
                  end
               end
            end else begin
               next_r.half = r.half + 5'h1;
            end
         end
         default: begin
            next_r.st = SPRSM_IDLE;
         end
      endcase

      // slave shifting on the external clock
      if (sel && sck_rise) begin
         next_r.rx_bit = mosi_q;
      end
      if (sel && sck_fall) begin
         next_r.shreg = {r.shreg[6:0], r.rx_bit};
         next_r.bitcnt = r.bitcnt + 3'h1;
         if (r.bitcnt == LAST_BIT) begin
            byte_done = 1'b1;
         end
      end
      if (r.port_en && !r.master_en && r.mode == MODE_4W_IN && nss_fall) begin
         next_r.bitcnt = 3'h0;
      end
      if (!r.port_en) begin
         next_r.bitcnt = 3'h0; // only way to realign 3-wire slave
      end

      // read data, valid only in the cycle after the strobe
      next_r.rdata = 8'h00;
      if (rd_strobe) begin
         if (hit(addr, OFF_CTRL)) begin
            next_r.rdata = {1'b0, r.rx_full, r.tx_full,
               r.st == SPRSM_SHIFT, r.mode, r.master_en, r.port_en};
         end else if (hit(addr, OFF_DATA)) begin
            next_r.rdata = r.rx_buf;
            next_r.rx_full = 1'b0;
         end else if (hit(addr, OFF_STAT)) begin
            next_r.rdata = {4'h0, r.stat};
         end else if (hit(addr, OFF_MASK)) begin
            next_r.rdata = {4'h0, r.mask};
         end
      end

      // end of byte: flag it and store the received byte
      // the read clear comes first so a byte landing in that cycle stays
      if (byte_done) begin
         ev[ST_DONE] = 1'b1;
         next_r.sh_full = 1'b0;
         if (r.master_en || !next_r.rx_full) begin
            next_r.rx_buf = {r.shreg[6:0], r.rx_bit};
            next_r.rx_full = 1'b1;
         end else begin
            ev[ST_OVR] = 1'b1; // slave overrun, byte lost
         end
      end

      // move the transmit buffer into an empty shift register
      if (next_r.tx_full && !next_r.sh_full && next_r.st == SPRSM_IDLE) begin
         next_r.shreg = next_r.tx_buf;
         next_r.sh_full = 1'b1;
         next_r.tx_full = 1'b0;
      end

      // fault takes the port off the bus
      if (fault) begin
         next_r.port_en = 1'b0;
         next_r.master_en = 1'b0;
         ev[ST_FAULT] = 1'b1;
      end

      // sticky status, write one to clear, a new event wins
      if (wr_strobe && hit(addr, OFF_STAT)) begin
         next_r.stat = (r.stat & ~wdata[3:0]) | ev;
      end else begin
         next_r.stat = r.stat | ev;
      end
      next_r.irq = |(next_r.stat & next_r.mask);

      // pin roles from the next configuration
      next_r.mosi_out = next_r.shreg[7];
      next_r.mosi_oe = next_r.port_en && next_r.master_en;
      next_r.sck_oe = next_r.port_en && next_r.master_en;
      next_r.miso_out = next_r.shreg[7];
      next_r.miso_oe = next_r.port_en && !next_r.master_en &&
         (next_r.mode == MODE_3W ||
         (next_r.mode == MODE_4W_IN && !nss_q));
      next_r.nss_oe = next_r.mode[1];
      next_r.nss_out = next_r.mode[0];
      next_r.nss_routed = next_r.mode != MODE_3W;
   end

   // register the whole state
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.st <= SPRSM_IDLE;
         r.mode <= MODE_RST;
         r.mask <= MASK_RST;
         r.shreg <= BYTE_RST;
         r.nss_d <= 1'b1;
         r.nss_routed <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state flops
   assign rdata = r.rdata;
   assign irq = r.irq;
   assign sck_out = r.sck_out;
   assign sck_oe = r.sck_oe;
   assign mosi_out = r.mosi_out;
   assign mosi_oe = r.mosi_oe;
   assign miso_out = r.miso_out;
   assign miso_oe = r.miso_oe;
   assign nss_out = r.nss_out;
   assign nss_oe = r.nss_oe;
   assign nss_routed = r.nss_routed;

   // checks on the pin roles and sequencing
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   AST_MOSI_ROLE: assert property (
      mosi_oe |-> r.port_en && r.master_en)
      else $error("mosi driven while not master");

   AST_MOSI_MSB: assert property (
      mosi_oe |-> mosi_out == r.shreg[7])
      else $error("mosi not from shift msb");

   AST_MISO_ROLE: assert property (
      miso_oe |-> !r.master_en && miso_out == r.shreg[7])
      else $error("miso driven wrongly");

   AST_MISO_OFF: assert property (
      (!r.port_en || r.master_en) |-> !miso_oe)
      else $error("miso not released");

   AST_SCK_ROLE: assert property (
      (r.st == SPRSM_SHIFT && r.half == SCK_HALF_LAST && r.port_en &&
      r.master_en) |=> sck_out != $past(sck_out))
      else $error("master sck did not toggle");

   AST_SCK_IGNORED: assert property (
      (r.port_en && !r.master_en && r.mode == MODE_4W_IN && nss_q &&
      r.nss_d && !wr_strobe) |=> r.bitcnt == $past(r.bitcnt))
      else $error("unselected slave counted sck");

   AST_FAULT: assert property (
      fault |=> !r.port_en && !r.master_en && r.stat[ST_FAULT])
      else $error("fault did not disable port");

   AST_NSS_OUT: assert property (
      (wr_strobe && hit(addr, OFF_CTRL) && wdata[CT_MODE_HI] && !fault)
      |=> nss_oe && nss_out == $past(wdata[CT_MODE_LO]))
      else $error("select output level wrong");

   AST_NSS_ROUTE: assert property (
      r.mode == MODE_3W |-> !nss_routed && !nss_oe)
      else $error("select routed in 3-wire mode");

   AST_BITCNT_RESET: assert property (
      (r.port_en && !r.master_en && r.mode == MODE_4W_IN && nss_fall &&
      !wr_strobe) |=> r.bitcnt == 3'h0)
      else $error("select fall kept bit count");

   AST_DONE_FLAG: assert property (
      byte_done |=> r.stat[ST_DONE] && !(r.sh_full && r.tx_full) ##0
      (r.rx_full || r.stat[ST_OVR]))
      else $error("byte end not flagged");
endmodule // sprsm_top

// ---- design/sprsm_pkg.sv ----
// constants, field positions and types shared by the serial port pin logic
package sprsm_pkg;
   // register offsets, byte addresses on the plain register port
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_DATA = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam logic [3:0] OFF_MASK = 4'hc;
   // control register fields
   localparam int CT_EN = 0;
   localparam int CT_MS = 1;
   localparam int CT_MODE_LO = 2;
   localparam int CT_MODE_HI = 3;
   localparam int CT_BUSY = 4;
   localparam int CT_TXF = 5;
   localparam int CT_RXF = 6;
   // status and mask register fields
   localparam int ST_DONE = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_OVR = 2;
   localparam int ST_WCOL = 3;
   // select mode encodings
   localparam logic [1:0] MODE_3W = 2'h0;
   localparam logic [1:0] MODE_4W_IN = 2'h1;
   // reset values
   localparam logic [1:0] MODE_RST = 2'h1;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // serial clock timing in master mode
   localparam int CLK_PERIOD_NS = 5;
   localparam int SCK_HALF_NS = 100;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam logic [4:0] SCK_HALF_LAST = 5'(SCK_HALF_CYC - 1);
   localparam logic [2:0] LAST_BIT = 3'h7;
   // synchroniser lanes
   localparam int SYNC_W = 4;
   localparam int SY_SCK = 0;
   localparam int SY_MOSI = 1;
   localparam int SY_MISO = 2;
   localparam int SY_NSS = 3;
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'h8; // select lane idles high
   // master sequencing states
   typedef enum logic [1:0] {
      SPRSM_IDLE = 2'b01,
      SPRSM_SHIFT = 2'b10
   } sprsm_st_e;
endpackage

// ---- design/sprsm_sync.sv ----
// two flip-flop synchroniser for the serial port pin inputs
`timescale 1ns/1ps
module sprsm_sync
   import sprsm_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic reset, // asynchronous, active high
   input wire logic [SYNC_W-1:0] din, // raw pin levels
   output logic [SYNC_W-1:0] q // synchronised levels
);
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } sprsm_sync_s;

   sprsm_sync_s r;
   sprsm_sync_s next_r;

   // first stage feeds only the second stage
   always_comb begin
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   // register both stages, select lane starts high: no false fall
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r.s1 <= SYNC_RST;
         r.s2 <= SYNC_RST;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.s2;
endmodule // sprsm_sync

// ---- verif/sprsm_peer.sv ----
// far side of the serial port: a slave for our master, a master for our slave
`timescale 1ns/1ps
module sprsm_peer (
   input wire logic sck, // serial clock pin level
   input wire logic mosi, // master-out pin level
   input wire logic miso, // master-in pin level
   input wire logic dev_master, // the device drives the clock
   output logic sck_drv, // clock drive while peer is master
   output logic mosi_drv, // master-out drive while peer is master
   output logic miso_drv // master-in drive while peer is slave
);
   logic [7:0] rx_byte;
   logic [7:0] sh;
   initial begin
      sck_drv = 1'b0;
      mosi_drv = 1'b0;
      miso_drv = 1'b0;
      rx_byte = 8'h00;
      sh = 8'h00;
   end
   // slave role: sample on the rising clock, msb first
   always @(posedge sck) begin
      if (dev_master) rx_byte <= {rx_byte[6:0], mosi};
   end
   // slave role: next bit out after the falling clock
   always @(negedge sck) begin
      if (dev_master) begin
         miso_drv <= sh[6];
         sh <= {sh[6:0], 1'b0};
      end
   end
   // preload the byte that the peer slave returns
   task automatic load(input logic [7:0] b);
      sh = b;
      miso_drv = b[7];
   endtask
   // master role: one byte, mode 0, clock still outside the frame
   task automatic xfer(input logic [7:0] b, output logic [7:0] got);
      for (int i = 7; i >= 0; i--) begin
         mosi_drv = b[i];
         #62.5 sck_drv = 1'b1;
         got[i] = miso;
         #62.5 sck_drv = 1'b0;
      end
      mosi_drv = ~mosi_drv; // line then holds the inverse of the last bit, not a stale one
   endtask
endmodule // sprsm_peer

// ---- verif/test_sprsm_top.sv ----
// self-checking bench for the serial port pin roles and select modes
`timescale 1ns/1ps
module test_sprsm_top;
   import sprsm_pkg::*;
   logic clock = 1'b0, reset = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, r, b, t, got;
   logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic nss_out, nss_oe, nss_routed, psck, pmosi, pmiso, flt = 1'b0;
   logic nss_drv = 1'b1;
   logic sck_pin, mosi_pin, miso_pin, nss_pin;
   int n_fail = 0, samples_checked = 0, seed = 31;
   // clock and a floating-line pattern that changes every cycle
   always #2.5 clock = ~clock;
   always @(posedge clock) flt <= ~flt;
   // pin levels from all drivers
   assign sck_pin = sck_oe ? sck_out : psck;
   assign mosi_pin = mosi_oe ? mosi_out : psck | ~sck_oe ? pmosi : flt;
   assign miso_pin = miso_oe ? miso_out : sck_oe ? pmiso : flt;
   assign nss_pin = nss_oe ? nss_out : nss_drv;
   sprsm_top i_sprsm_top (.clock(clock), .reset(reset), .addr(addr),
      .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .rdata(rdata), .irq(irq), .sck_in(sck_pin), .sck_out(sck_out),
      .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
      .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out),
      .miso_oe(miso_oe), .nss_in(nss_pin), .nss_out(nss_out),
      .nss_oe(nss_oe), .nss_routed(nss_routed));
   sprsm_peer i_sprsm_peer (.sck(sck_pin), .mosi(mosi_pin),
      .miso(miso_pin), .dev_master(sck_oe), .sck_drv(psck),
      .mosi_drv(pmosi), .miso_drv(pmiso));
   // compare one value and count it
   task automatic chk(input string what, input logic [7:0] e,
         input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // register write, one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1'b1;
      @(posedge clock);
      wr_strobe <= 1'b0;
   endtask
   // register read, data taken in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clock);
      rd_strobe <= 1'b0;
      #1 d = rdata;
   endtask
   // wait for the interrupt under a bounded count
   task automatic wait_irq();
      for (int n = 0; n < 2000 && irq !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      if (irq !== 1'b1) begin
         n_fail++;
         $display("[FAIL] irq wait expected 1 seen %b", irq);
      end
   endtask
   // settle a few cycles past the synchronisers
   task automatic settle();
      repeat (6) @(posedge clock);
      #1;
   endtask
   // print counts and verdict, then end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd(OFF_CTRL, r);
      chk("ctrl reset", 8'h04, r);
      rd(OFF_MASK, r);
      chk("mask reset", {4'h0, MASK_RST}, r);
      chk("routed reset", 8'h01, {7'h0, nss_routed});
      chk("miso off disabled", 8'h00, {7'h0, miso_oe});
      wr(OFF_MASK, 8'h01);
      // master transfers with random bytes both ways
      for (int k = 0; k < 3; k++) begin
         b = 8'($random(seed));
         t = 8'($random(seed));
         wr(OFF_CTRL, 8'h07);
         i_sprsm_peer.load(t);
         wr(OFF_DATA, b);
         #1 chk("master pins", 8'h03, {6'h0, mosi_oe, sck_oe});
         chk("master miso in", 8'h00, {7'h0, miso_oe});
         wait_irq();
         chk("master irq", 8'h01, {7'h0, irq});
         chk("peer got", b, i_sprsm_peer.rx_byte);
         rd(OFF_DATA, r);
         chk("master rx", t, r);
         wr(OFF_STAT, 8'h01);
         settle();
         chk("irq cleared", 8'h00, {7'h0, irq});
      end
      // select output modes, used only as master
      for (int m = 2; m < 4; m++) begin
         wr(OFF_CTRL, 8'((m << 2) | 3));
         settle();
         chk("nss drive", {6'h0, 1'b1, 1'(m)}, {6'h0, nss_oe, nss_out});
         chk("nss routed 1x", 8'h01, {7'h0, nss_routed});
      end
      wr(OFF_CTRL, 8'h03);
      settle();
      chk("nss 3-wire", 8'h00, {6'h0, nss_oe, nss_routed});
      // multi-master fault on a select fall
      wr(OFF_CTRL, 8'h07);
      nss_drv <= 1'b0;
      settle();
      rd(OFF_CTRL, r);
      chk("fault enables", 8'h00, r & 8'h03);
      rd(OFF_STAT, r);
      chk("fault flag", 8'h02, r & 8'h02);
      chk("fault pins", 8'h00, {6'h0, mosi_oe, sck_oe});
      nss_drv <= 1'b1;
      wr(OFF_STAT, 8'h0f);
      // 4-wire slave, unselected then selected
      wr(OFF_CTRL, 8'h05);
      t = 8'($random(seed));
      wr(OFF_DATA, t);
      settle();
      chk("slave unselected", 8'h00, {7'h0, miso_oe});
      chk("slave pins in", 8'h00, {6'h0, mosi_oe, sck_oe});
      i_sprsm_peer.xfer(8'h3c, got);
      settle();
      rd(OFF_STAT, r);
      chk("sck ignored", 8'h00, r & 8'h01);
      nss_drv <= 1'b0;
      settle();
      chk("slave selected", 8'h01, {7'h0, miso_oe});
      b = 8'($random(seed));
      i_sprsm_peer.xfer(b, got);
      wait_irq();
      chk("slave tx", t, got);
      rd(OFF_DATA, r);
      chk("slave rx", b, r);
      nss_drv <= 1'b1;
      wr(OFF_STAT, 8'h0f);
      // 3-wire slave, always selected
      wr(OFF_CTRL, 8'h01);
      wr(OFF_DATA, 8'ha5);
      settle();
      chk("3w slave drive", 8'h03, {6'h0, miso_oe, miso_out});
      chk("3w unrouted", 8'h00, {7'h0, nss_routed});
      i_sprsm_peer.xfer(8'h5a, got);
      wait_irq();
      chk("3w tx", 8'ha5, got);
      rd(OFF_DATA, r);
      chk("3w rx", 8'h5a, r);
      // buffered byte, write collision, then overrun on an unread byte
      wr(OFF_DATA, 8'h11);
      wr(OFF_DATA, 8'h22);
      wr(OFF_DATA, 8'h33);
      rd(OFF_STAT, r);
      chk("write collision", 8'h08, r & 8'h08);
      i_sprsm_peer.xfer(8'hc3, got);
      chk("3w tx next", 8'h11, got);
      settle();
      i_sprsm_peer.xfer(8'h96, got);
      chk("3w tx buffered", 8'h22, got);
      settle();
      rd(OFF_STAT, r);
      chk("overrun", 8'h04, r & 8'h04);
      rd(OFF_DATA, r);
      chk("overrun kept", 8'hc3, r);
      wr(OFF_CTRL, 8'h00);
      settle();
      chk("miso off again", 8'h00, {7'h0, miso_oe});
      stop_test();
   end
endmodule // test_sprsm_top
